//--- hdl/mcab_core.sv
// Datapath for literal/file add and AND, bit set/clear, skip-if-set and clear-file
`timescale 1ns/10ps
`default_nettype none
module mcab_core
    import mcab_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                reset_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [31:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    input  wire logic                instr_valid_i,
    input  wire mcab_pkg::mcab_op_t  instr_op_i,
    input  wire logic [7:0]          instr_lit_i,
    input  wire logic [6:0]          instr_file_i,
    input  wire logic                instr_dest_i,
    input  wire logic [2:0]          instr_bit_i,
    output logic                     instr_taken_o,
    output logic                     cycle_done_o,
    output logic                     skip_active_o,
    output logic      [6:0]          file_addr_o,
    input  wire logic [7:0]          file_rd_data_i,
    input  wire logic                file_is_port_i,
    input  wire logic [7:0]          port_pins_i,
    output logic                     file_wr_en_o,
    output logic      [7:0]          file_wr_data_o,
    output logic      [7:0]          acc_o
);
    import mcab_pkg::*;

    logic [1:0]  phase;
    logic        run;
    logic        busy;
    logic        skip_pending;
    mcab_op_t    op;
    logic [7:0]  lit;
    logic        dest;
    logic [2:0]  bit_sel;
    logic [7:0]  operand;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    logic [7:0]  pin_s3;
    logic [7:0]  pin_level;
    logic        flag_c;
    logic        flag_digit;
    logic        flag_z;

    logic [7:0]  add_b;
    logic [7:0]  add_sum;
    logic        add_c;
    logic        add_digit;
    logic [7:0]  next_result;
    logic        next_wr_acc;
    logic        next_wr_file;
    logic        next_upd_cdc;
    logic        next_upd_z;
    logic        next_z;
    logic        next_skip;
    logic        commit;
    logic        apb_write;
    logic        apb_access;

    assign commit     = busy && (phase == ph_write);
    assign apb_access = psel_i && penable_i;
    assign apb_write  = apb_access && pwrite_i && pready_o;

    // Each instruction cycle is four phases, each one oscillator period long
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase <= ph_fetch;
        end else if (run || phase != ph_fetch) begin
            phase <= phase + 2'h1;
        end
    end

    // Instruction latch; a pending skip turns the fetched word into a no-op
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy          <= 1'b0;
            op            <= mcab_nop;
            lit           <= byte_zero;
            dest          <= 1'b0;
            bit_sel       <= 3'h0;
            file_addr_o   <= 7'h00;
            instr_taken_o <= 1'b0;
            skip_active_o <= 1'b0;
        end else begin
            instr_taken_o <= 1'b0;
            if (phase == ph_fetch) begin
                skip_active_o <= 1'b0;
                busy          <= 1'b0;
                if (run && instr_valid_i) begin
                    busy          <= 1'b1;
                    instr_taken_o <= 1'b1;
                    op            <= skip_pending ? mcab_nop : instr_op_i;
                    skip_active_o <= skip_pending;
                    lit           <= instr_lit_i;
                    dest          <= instr_dest_i;
                    bit_sel       <= instr_bit_i;
                    file_addr_o   <= instr_file_i;
                end
            end
        end
    end

    // Pin levels settle once the second and third stages agree
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_s1    <= byte_zero;
            pin_s2    <= byte_zero;
            pin_s3    <= byte_zero;
            pin_level <= byte_zero;
        end else begin
            pin_s1    <= port_pins_i;
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_level <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_level);
        end
    end

    // Operand fetch; port registers read back what the pins show
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            operand <= byte_zero;
        end else if (busy && phase == ph_read) begin
            operand <= file_is_port_i ? pin_level : file_rd_data_i;
        end
    end

    assign add_b = (op == add_literal_to_acc) ? lit : operand;

    mcab_add8 u_add (
        .a_i           (acc_o),
        .b_i           (add_b),
        .sum_o         (add_sum),
        .carry_o       (add_c),
        .digit_carry_o (add_digit)
    );

    always_comb begin
        next_result  = byte_zero;
        next_wr_acc  = 1'b0;
        next_wr_file = 1'b0;
        next_upd_cdc = 1'b0;
        next_upd_z   = 1'b0;
        next_skip    = 1'b0;
        unique case (op)
            add_literal_to_acc: begin
                next_result  = add_sum;
                next_wr_acc  = 1'b1;
                next_upd_cdc = 1'b1;
                next_upd_z   = 1'b1;
            end
            add_acc_to_file: begin
                next_result  = add_sum;
                next_wr_acc  = !dest;
                next_wr_file = dest;
                next_upd_cdc = 1'b1;
                next_upd_z   = 1'b1;
            end
            and_literal_with_acc: begin
                next_result = acc_o & lit;
                next_wr_acc = 1'b1;
                next_upd_z  = 1'b1;
            end
            and_acc_with_file: begin
                next_result  = acc_o & operand;
                next_wr_acc  = !dest;
                next_wr_file = dest;
                next_upd_z   = 1'b1;
            end
            bit_clear_op: begin
                next_result  = operand & ~(bit_one << bit_sel);
                next_wr_file = 1'b1;
            end
            bit_set_op: begin
                next_result  = operand | (bit_one << bit_sel);
                next_wr_file = 1'b1;
            end
            skip_if_bit_set_op: begin
                next_skip = operand[bit_sel];
            end
            clear_file_op: begin
                next_result  = byte_zero;
                next_wr_file = 1'b1;
                next_upd_z   = 1'b1;
            end
            mcab_nop: begin
                next_result = byte_zero;
            end
            default: ;
        endcase
        next_z = (next_result == byte_zero);
    end

    // Accumulator: a committing instruction wins over a bus write
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_o <= acc_reset;
        end else if (commit && next_wr_acc) begin
            acc_o <= next_result;
        end else if (apb_write && paddr_i == acc_addr) begin
            acc_o <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            {flag_z, flag_digit, flag_c} <= status_reset;
        end else if (commit && (next_upd_cdc || next_upd_z)) begin
            if (next_upd_cdc) begin
                flag_c     <= add_c;
                flag_digit <= add_digit;
            end
            flag_z <= next_z;
        end else if (apb_write && paddr_i == status_addr) begin
            flag_c     <= pwdata_i[flag_c_bit];
            flag_digit <= pwdata_i[flag_digit_bit];
            flag_z     <= pwdata_i[flag_z_bit];
        end
    end

    // File write strobe lasts one oscillator period, in the fetch phase that follows the write phase
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            file_wr_en_o   <= 1'b0;
            file_wr_data_o <= byte_zero;
            cycle_done_o   <= 1'b0;
        end else begin
            file_wr_en_o <= commit && next_wr_file;
            cycle_done_o <= commit;
            if (commit && next_wr_file) begin
                file_wr_data_o <= next_result;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            skip_pending <= 1'b0;
        end else if (commit) begin
            skip_pending <= next_skip;
        end else if (phase == ph_fetch && run && instr_valid_i) begin
            skip_pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            run <= ctrl_reset[ctrl_run_bit];
        end else if (apb_write && paddr_i == ctrl_addr) begin
            run <= pwdata_i[ctrl_run_bit];
        end
    end

    // APB slave: one wait state so read data comes from a flip-flop
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= apb_access && !pready_o;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            if (apb_access && !pready_o) begin
                unique case (paddr_i)
                    acc_addr:    prdata_o <= {24'h00_0000, acc_o};
                    status_addr: prdata_o <= {29'h0000_0000, flag_z, flag_digit, flag_c};
                    ctrl_addr:   prdata_o <= {31'h0000_0000, run};
                    state_addr:  prdata_o <= {27'h000_0000, busy, skip_pending, skip_active_o, phase};
                    default:     pslverr_o <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- inc/mcab_pkg.sv
// Constants and types shared by the arithmetic and bit-operation datapath
package mcab_pkg;
    // APB register byte addresses
    localparam logic [31:0] acc_addr    = 32'h0000_0000;
    localparam logic [31:0] status_addr = 32'h0000_0004;
    localparam logic [31:0] ctrl_addr   = 32'h0000_0008;
    localparam logic [31:0] state_addr  = 32'h0000_000c;

    // Status field positions
    localparam int          flag_c_bit  = 0;
    localparam int          flag_digit_bit = 1;
    localparam int          flag_z_bit  = 2;

    // Control field positions and reset values
    localparam int          ctrl_run_bit   = 0;
    localparam logic [31:0] ctrl_reset     = 32'h0000_0001;
    localparam logic [7:0]  acc_reset      = 8'h00;
    localparam logic [2:0]  status_reset   = 3'h0;

    // State register field positions
    localparam int          state_phase_lsb  = 0;
    localparam int          state_active_bit = 2;
    localparam int          state_skip_bit   = 3;
    localparam int          state_busy_bit   = 4;

    // Instruction cycle timing, in oscillator periods of ref_clk_i
    localparam int          osc_per_cycle = 4;
    localparam logic [1:0]  ph_fetch      = 2'h0;
    localparam logic [1:0]  ph_read       = 2'h1;
    localparam logic [1:0]  ph_exec       = 2'h2;
    localparam logic [1:0]  ph_write      = 2'(osc_per_cycle - 1);

    localparam logic [7:0]  byte_zero = 8'h00;
    localparam logic [7:0]  bit_one   = 8'h01;

    typedef enum logic [3:0] {
        mcab_nop,
        add_literal_to_acc,
        add_acc_to_file,
        and_literal_with_acc,
        and_acc_with_file,
        bit_clear_op,
        bit_set_op,
        skip_if_bit_set_op,
        clear_file_op
    } mcab_op_t;
endpackage

//--- hdl/mcab_add8.sv
// Eight-bit adder with carry out of bits 3 and 7
`timescale 1ns/10ps
`default_nettype none
module mcab_add8 (
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    output logic      [7:0] sum_o,
    output logic            carry_o,
    output logic            digit_carry_o
);
    logic [4:0] low_sum;
    logic [8:0] full_sum;

    always_comb begin
        low_sum       = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        full_sum      = {1'b0, a_i} + {1'b0, b_i};
        sum_o         = full_sum[7:0];
        carry_o       = full_sum[8];
        digit_carry_o = low_sum[4];
    end
endmodule
`default_nettype wire

//--- tb/mcab_chk.sv
// Concurrent checks on the datapath's instruction and bus ports
`timescale 1ns/10ps
`default_nettype none
module mcab_chk (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic [31:0] paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        instr_valid_i,
    input wire logic [6:0]  instr_file_i,
    input wire logic        instr_taken_o,
    input wire logic        cycle_done_o,
    input wire logic        skip_active_o,
    input wire logic [6:0]  file_addr_o,
    input wire logic        file_wr_en_o,
    input wire logic [7:0]  acc_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    a_taken_needs_valid: assert property (instr_taken_o |-> $past(instr_valid_i))
        else $error("instruction taken without valid");
    a_done_after_take: assert property (instr_taken_o |-> ##3 (cycle_done_o || skip_active_o))
        else $error("no completion three cycles after acceptance");
    a_done_gap: assert property (cycle_done_o |=> !cycle_done_o [*3])
        else $error("completions closer than four cycles");
    a_write_with_done: assert property (file_wr_en_o |-> cycle_done_o)
        else $error("file write outside a completed cycle");
    a_skip_no_write: assert property (skip_active_o |-> !file_wr_en_o)
        else $error("discarded instruction wrote a file register");
    a_skip_acc_hold: assert property (skip_active_o && !$past(pready_o) |-> $stable(acc_o))
        else $error("discarded instruction changed the accumulator");
    a_addr_hold: assert property (!instr_taken_o |-> $stable(file_addr_o))
        else $error("file address moved between acceptances");
    a_addr_taken: assert property (instr_taken_o |-> file_addr_o == $past(instr_file_i))
        else $error("file address differs from the accepted one");
    a_unmapped_err: assert property (pready_o && paddr_i[31:4] != 28'h0 |-> pslverr_o)
        else $error("unmapped access without error");
    c_skip: cover property (skip_active_o);
    c_back_to_back: cover property (instr_taken_o ##4 instr_taken_o);
    c_bus_error: cover property (pready_o && pslverr_o);
endmodule
bind mcab_core mcab_chk i_mcab_chk (
    .ref_clk_i     (ref_clk_i),
    .reset_i       (reset_i),
    .paddr_i       (paddr_i),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o),
    .instr_valid_i (instr_valid_i),
    .instr_file_i  (instr_file_i),
    .instr_taken_o (instr_taken_o),
    .cycle_done_o  (cycle_done_o),
    .skip_active_o (skip_active_o),
    .file_addr_o   (file_addr_o),
    .file_wr_en_o  (file_wr_en_o),
    .acc_o         (acc_o)
);
`default_nettype wire

//--- tb/mcab_file_model.sv
// Behavioural file register space seen by the datapath
`timescale 1ns/10ps
`default_nettype none
module mcab_file_model #(
    parameter logic [6:0] port_file = 7'h05
) (
    input  wire logic       ref_clk_i,
    input  wire logic [6:0] file_addr_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_data_i,
    output logic      [7:0] rd_data_o,
    output logic            is_port_o
);
    logic [7:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 17);
    always @(posedge ref_clk_i) if (wr_en_i) mem[file_addr_i] <= wr_data_i;
    // Port answers with its latch, so reading the wrong source shows up
    assign rd_data_o = mem[file_addr_i];
    assign is_port_o = (file_addr_i == port_file);
endmodule
`default_nettype wire

//--- tb/mcab_core_tb_top.sv
// Self-checking bench for the arithmetic and bit-operation datapath
`timescale 1ns/10ps
`default_nettype none
module mcab_core_tb_top;
    import mcab_pkg::*;
    typedef struct packed {logic [7:0] acc; logic skip; logic wr; logic [7:0] wd;} mcab_note_t;
    localparam logic [6:0] port_file = 7'h05;
    logic        ref_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
    logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o;
    logic        instr_valid_i = 0, instr_dest_i = 0, instr_taken_o, cycle_done_o, skip_active_o;
    logic        file_is_port_i, file_wr_en_o, skip_pend = 0;
    logic [7:0]  instr_lit_i = 0, file_rd_data_i, port_pins_i = 8'ha5, file_wr_data_o, acc_o, acc;
    logic [7:0]  mem [128];
    logic [6:0]  instr_file_i = 0, file_addr_o;
    logic [2:0]  instr_bit_i = 0, fl;
    mcab_op_t    instr_op_i = mcab_nop;
    mcab_note_t  q[$];
    int          num_errors = 0, tests_run = 0;

    always #5 ref_clk_i = ~ref_clk_i;
    mcab_core i_mcab_core (.*);
    mcab_file_model #(.port_file(port_file)) i_mcab_file_model (.ref_clk_i(ref_clk_i), .file_addr_i(file_addr_o),
        .wr_en_i(file_wr_en_o), .wr_data_i(file_wr_data_o), .rd_data_o(file_rd_data_i), .is_port_o(file_is_port_i));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("tests_run %0d num_errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic e);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Reference result is worked out before the word is offered
    task automatic issue(input mcab_op_t op, input logic [7:0] lit, input logic [6:0] f, input logic d,
                         input logic [2:0] b, input logic fast);
        logic [7:0] opnd, bs, r;
        logic [8:0] s;
        logic [31:0] rd;
        logic e;
        mcab_note_t n;
        opnd = (f == port_file) ? port_pins_i : mem[f];
        n = '{acc, skip_pend, 1'b0, 8'h00};
        if (skip_pend) begin
            skip_pend = 1'b0;
        end else begin
            bs = (op inside {add_literal_to_acc, and_literal_with_acc}) ? lit : opnd;
            s = acc + bs;
            r = 8'h00;
            case (op)
                add_literal_to_acc, add_acc_to_file: begin
                    r = s[7:0];
                    fl[0] = s[8];
                    fl[1] = (5'(acc[3:0]) + 5'(bs[3:0])) > 5'h0f;
                end
                and_literal_with_acc, and_acc_with_file: r = acc & bs;
                bit_clear_op: r = opnd & ~(8'h01 << b);
                bit_set_op: r = opnd | (8'h01 << b);
                skip_if_bit_set_op: skip_pend = opnd[b];
                default: ;
            endcase
            if (!(op inside {bit_clear_op, bit_set_op, skip_if_bit_set_op})) fl[2] = (r == 8'h00);
            n.wr = op inside {bit_clear_op, bit_set_op, clear_file_op} ||
                   (d && op inside {add_acc_to_file, and_acc_with_file});
            if (n.wr) mem[f] = r;
            else if (op != skip_if_bit_set_op) acc = r;
            n.wd = r;
            n.acc = acc;
        end
        q.push_back(n);
        instr_op_i <= op;
        instr_lit_i <= lit;
        instr_file_i <= f;
        instr_dest_i <= d;
        instr_bit_i <= b;
        instr_valid_i <= 1'b1;
        do @(posedge ref_clk_i); while (instr_taken_o !== 1'b1);
        if (!fast) begin
            instr_valid_i <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            apb(1'b0, status_addr, 32'h0, rd, e);
            chk(rd[7:0], {5'h0, fl});
        end
    endtask

    initial forever begin
        mcab_note_t n;
        @(posedge ref_clk_i);
        if (instr_taken_o === 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            repeat (3) @(posedge ref_clk_i);
            chk(acc_o, n.acc);
            chk(8'(skip_active_o), 8'(n.skip));
            chk(8'(file_wr_en_o), 8'(n.wr));
            if (n.wr) chk(file_wr_data_o, n.wd);
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        complete_run();
    end

    initial begin
        logic [31:0] rd;
        logic e;
        int unused;
        unused = $urandom(32'h13a9);
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 17);
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        apb(1'b0, acc_addr, 32'h0, rd, e);
        chk(rd[7:0], acc_reset);
        chk(8'(e), 8'h00);
        apb(1'b0, ctrl_addr, 32'h0, rd, e);
        chk(rd[7:0], ctrl_reset[7:0]);
        apb(1'b0, 32'h10, 32'h0, rd, e);
        chk(8'(e), 8'h01);
        fl = 3'($urandom);
        apb(1'b1, status_addr, {29'h0, fl}, rd, e);
        apb(1'b0, status_addr, 32'h0, rd, e);
        chk(rd[7:0], {5'h0, fl});
        apb(1'b1, ctrl_addr, 32'h0, rd, e);
        instr_valid_i <= 1'b1;
        repeat (8) begin
            @(posedge ref_clk_i);
            chk(8'(instr_taken_o), 8'h00);
        end
        instr_valid_i <= 1'b0;
        // Stopped core sits idle in the first phase
        apb(1'b0, state_addr, 32'h0, rd, e);
        chk(rd[7:0], 8'h00);
        apb(1'b1, ctrl_addr, 32'h1, rd, e);
        acc = 8'h01;
        apb(1'b1, acc_addr, 32'h1, rd, e);
        issue(add_literal_to_acc, 8'hff, 7'h00, 1'b0, 3'h0, 1'b0);
        issue(add_acc_to_file, 8'h00, 7'h03, 1'b1, 3'h0, 1'b1);
        issue(and_acc_with_file, 8'h00, 7'h03, 1'b0, 3'h0, 1'b0);
        issue(bit_set_op, 8'h00, port_file, 1'b0, 3'h6, 1'b1);
        issue(bit_clear_op, 8'h00, port_file, 1'b0, 3'h0, 1'b0);
        issue(skip_if_bit_set_op, 8'h00, 7'h7f, 1'b0, 3'h6, 1'b1);
        issue(clear_file_op, 8'h00, 7'h02, 1'b0, 3'h0, 1'b0);
        issue(skip_if_bit_set_op, 8'h00, 7'h7f, 1'b0, 3'h7, 1'b0);
        issue(clear_file_op, 8'h00, 7'h7f, 1'b0, 3'h0, 1'b0);
        issue(and_literal_with_acc, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0);
        for (int k = 0; k < 40; k++) begin
            issue(mcab_op_t'(4'($urandom_range(8, 1))), 8'($urandom), 7'($urandom_range(127, 8)), 1'($urandom),
                  3'($urandom), 1'($urandom));
        end
        instr_valid_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        // Every offered word must have been accepted and checked
        chk(8'(q.size()), 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
